/* File: program_rom.sv */
`default_nettype none

package address_map_pkg;
	localparam logic [15:0] VECTOR_BASE      = 16'h0000;
	localparam logic [15:0] VECTOR_LAST      = 16'h000D;
	localparam logic [15:0] RESET_VECTOR_LO  = 16'h0000;
	localparam logic [15:0] RESET_VECTOR_HI  = 16'h0001;
	localparam logic [15:0] CALL_TABLE_BASE  = 16'h0040;
	localparam logic [15:0] CALL_TABLE_LAST  = 16'h007F;
	localparam logic [15:0] PROG_ROM_LAST    = 16'h0FFF;
	localparam logic [15:0] NV_DATA_BASE     = 16'hF800;
	localparam logic [15:0] NV_DATA_LAST     = 16'hF81F;
	localparam logic [15:0] HIGH_RAM_BASE    = 16'hFE80;
	localparam logic [15:0] HIGH_RAM_LAST    = 16'hFEFF;
	localparam logic [15:0] SFR_BASE         = 16'hFF00;
	localparam logic [15:0] SFR_LAST         = 16'hFFFF;
	localparam logic [2:0]  VECTOR_SLOTS     = 3'h7;
	localparam int          PROG_ROM_BYTES   = 4096;
	localparam int          PROG_ADDR_WIDTH  = 12;
	localparam logic [7:0]  UNMAPPED_BYTE    = 8'h00;
	localparam logic [15:0] POINTER_RESET    = 16'h0000;

	// one-hot phases of the reset vector load
	typedef enum logic [3:0] {
		PH_FETCH_LO = 4'h1,
		PH_FETCH_HI = 4'h2,
		PH_LOAD     = 4'h4,
		PH_RUN      = 4'h8
	} phase_type;
endpackage : address_map_pkg

module program_rom #(
	parameter int AW    = address_map_pkg::PROG_ADDR_WIDTH,
	parameter int DEPTH = address_map_pkg::PROG_ROM_BYTES
) (
	input  wire logic          clk,
	input  wire logic          reset,
	input  wire logic [AW-1:0] readAddr,
	input  wire logic          loadEnable,
	input  wire logic [AW-1:0] loadAddr,
	input  wire logic [7:0]    loadData,
	output logic      [7:0]    readData
);
	logic [7:0] mem [DEPTH];

	// programming port stands in for mask contents or reprogramming
	always_ff @(posedge clk) begin
		if (loadEnable) begin
			mem[loadAddr] <= loadData;
		end
	end

	// registered read, one cycle of latency
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			readData <= address_map_pkg::UNMAPPED_BYTE;
		end else begin
			readData <= mem[readAddr];
		end
	end
endmodule : program_rom

`default_nettype wire

/* File: cpu_address_map_reset_vector.sv */
// Overview of operation
// R1 - Addresses are 16 bits wide and cover one 64 KB space shared by program and data.
// R2 - Bytes 0000H to 000DH form the vector table and are not ordinary code.
// R3 - A vector is a 16-bit address with its low byte at the even and its high byte at the odd address.
// R4 - Slots are reset 0000H, key return 0002H, watchdog 0004H, timers 0006H and 0008H, low voltage 000AH, nonvolatile 000CH.
// R5 - Bytes 0040H to 007FH hold entry addresses for the one-byte table call instruction.
// R6 - Internal program memory holds 4096 bytes of mask or reprogrammable storage.
// R7 - Addresses FE80H to FEFFH select the high-speed RAM, which also holds the stack.
// R8 - Addresses F800H to F81FH select the nonvolatile data memory.
// R9 - Addresses FF00H to FFFFH select the special function registers.
// R10 - The window FE80H to FFFFH supports the short addressing modes.
// R11 - The next fetch pointer is 16 bits and holds the address of the next instruction.
// R12 - In sequence the pointer advances by the byte length of each fetched instruction.
// R13 - A branch loads the pointer from the instruction target or from a register.
// R14 - After reset the pointer is loaded from 0000H (low byte) and 0001H (high byte).
// R15 - The outside system holds the reset pin low to reset the device.
// R16 - Addresses outside every region select nothing, read as zero and drop writes.
`default_nettype none

module cpu_address_map_reset_vector #(
	parameter int AW = address_map_pkg::PROG_ADDR_WIDTH
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        fetchStep,
	input  wire logic [2:0]  instrLength,
	input  wire logic        branchTake,
	input  wire logic [15:0] branchTarget,
	input  wire logic [2:0]  vectorSource,
	input  wire logic [4:0]  callSlot,
	input  wire logic [15:0] dataAddr,
	input  wire logic        dataRead,
	input  wire logic        dataWrite,
	input  wire logic        romLoadEnable,
	input  wire logic [AW-1:0] romLoadAddr,
	input  wire logic [7:0]  romLoadData,
	output logic      [15:0] nextFetchPointer,
	output logic             pointerReady,
	output logic      [7:0]  fetchByte,
	output logic      [15:0] vectorAddr,
	output logic      [15:0] callTableAddr,
	output logic             selVectorTable,
	output logic             selCallTable,
	output logic             selProgRom,
	output logic             selNvData,
	output logic             selHighRam,
	output logic             selSfr,
	output logic             selShortWindow,
	output logic             selNone,
	output logic             writeAllowed
);
	typedef struct packed {
		address_map_pkg::phase_type phase;
		logic [15:0]                pointer;
		logic [7:0]                 lowByte;
		logic                       romInRange;
	} state_type;

	state_type         state_reg;
	state_type         state_next;
	logic [7:0]        romReadData;
	logic [AW-1:0]     romAddr;
	logic              dataAccess;
	logic              inProgRom;

	// R6 program store, one registered read port
	program_rom #(
		.AW    (AW),
		.DEPTH (address_map_pkg::PROG_ROM_BYTES)
	) progStore (
		.clk        (clk),
		.reset      (reset),
		.readAddr   (romAddr),
		.loadEnable (romLoadEnable),
		.loadAddr   (romLoadAddr),
		.loadData   (romLoadData),
		.readData   (romReadData)
	);

	// R14 vector bytes are read first, then the pointer drives fetch
	always_comb begin
		case (state_reg.phase)
			address_map_pkg::PH_FETCH_LO: romAddr = address_map_pkg::RESET_VECTOR_LO[AW-1:0];
			address_map_pkg::PH_FETCH_HI: romAddr = address_map_pkg::RESET_VECTOR_HI[AW-1:0];
			default:                      romAddr = state_reg.pointer[AW-1:0];
		endcase
	end

	// sequencing of the next fetch pointer
	always_comb begin
		state_next = state_reg;
		// R16 byte leaving the store next cycle came from inside it
		state_next.romInRange = (state_reg.phase == address_map_pkg::PH_RUN)
			&& (state_reg.pointer <= address_map_pkg::PROG_ROM_LAST);
		case (state_reg.phase)
			address_map_pkg::PH_FETCH_LO: begin
				state_next.phase = address_map_pkg::PH_FETCH_HI;
			end
			address_map_pkg::PH_FETCH_HI: begin
				// R3 even address carries the low byte
				state_next.lowByte = romReadData;
				state_next.phase   = address_map_pkg::PH_LOAD;
			end
			address_map_pkg::PH_LOAD: begin
				// R14 odd address carries the high byte
				state_next.pointer = {romReadData, state_reg.lowByte};
				state_next.phase   = address_map_pkg::PH_RUN;
			end
			address_map_pkg::PH_RUN: begin
				if (branchTake) begin
					// R13 target or register contents
					state_next.pointer = branchTarget;
				end else if (fetchStep) begin
					// R12 advance by instruction length, wraps at 64 KB
					state_next.pointer = state_reg.pointer + {13'h0000, instrLength};
				end
			end
			default: begin
				state_next.phase = address_map_pkg::PH_FETCH_LO;
			end
		endcase
	end

	// R11 sixteen-bit pointer, cleared until the vector arrives
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg.phase   <= address_map_pkg::PH_FETCH_LO;
			state_reg.pointer <= address_map_pkg::POINTER_RESET;
			state_reg.lowByte <= 8'h00;
			state_reg.romInRange <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign nextFetchPointer = state_reg.pointer;
	assign pointerReady     = (state_reg.phase == address_map_pkg::PH_RUN);

	// R16 fetch beyond the program store reads as zero
	assign fetchByte = inProgRom ? romReadData : address_map_pkg::UNMAPPED_BYTE;

	// range flag travels one cycle behind the pointer, as the read data do
	assign inProgRom = state_reg.romInRange;

	// R4 two bytes per slot, seven slots; out-of-range source falls back to reset
	assign vectorAddr = (vectorSource < address_map_pkg::VECTOR_SLOTS) ?
		address_map_pkg::VECTOR_BASE + {12'h000, vectorSource, 1'b0} : address_map_pkg::RESET_VECTOR_LO;

	// R5 two-byte entries from the table base
	assign callTableAddr = address_map_pkg::CALL_TABLE_BASE + {10'h000, callSlot, 1'b0};

	// R1 decode over the full 16-bit space, only during an access
	assign dataAccess = dataRead || dataWrite;
	// R2 vector table window
	assign selVectorTable = dataAccess && (dataAddr <= address_map_pkg::VECTOR_LAST);
	// R5 table call window
	assign selCallTable = dataAccess && (dataAddr >= address_map_pkg::CALL_TABLE_BASE)
		&& (dataAddr <= address_map_pkg::CALL_TABLE_LAST);
	assign selProgRom = dataAccess && (dataAddr <= address_map_pkg::PROG_ROM_LAST);
	// R8 nonvolatile data window
	assign selNvData = dataAccess && (dataAddr >= address_map_pkg::NV_DATA_BASE)
		&& (dataAddr <= address_map_pkg::NV_DATA_LAST);
	// R7 high-speed RAM and stack
	assign selHighRam = dataAccess && (dataAddr >= address_map_pkg::HIGH_RAM_BASE)
		&& (dataAddr <= address_map_pkg::HIGH_RAM_LAST);
	// R9 special function registers
	assign selSfr = dataAccess && (dataAddr >= address_map_pkg::SFR_BASE);
	// R10 short addressing window spans RAM and registers
	assign selShortWindow = selHighRam || selSfr;
	// R16 nothing selected, write dropped
	assign selNone = dataAccess && !selProgRom && !selNvData && !selHighRam && !selSfr;
	// program store is read-only from the data side
	assign writeAllowed = dataWrite && (selNvData || selHighRam || selSfr);

	a_vector_low_first: assert property (@(posedge clk) disable iff (reset) // R14
		(state_reg.phase == address_map_pkg::PH_FETCH_LO) |-> (romAddr == 12'h000) ##1 (romAddr == 12'h001))
		else $error("reset vector bytes not read from 0000H then 0001H");

	a_vector_pointer_load: assert property (@(posedge clk) disable iff (reset) // R3
		(state_reg.phase == address_map_pkg::PH_LOAD) |=>
		(nextFetchPointer == {$past(romReadData), $past(state_reg.lowByte)}) && pointerReady)
		else $error("pointer not loaded with high and low vector bytes");

	a_ready_after_three: assert property (@(posedge clk) disable iff (reset) // R11
		$rose(state_reg.phase == address_map_pkg::PH_FETCH_HI) |-> ##2 pointerReady)
		else $error("pointer not ready two cycles after vector read");

	a_sequential_advance: assert property (@(posedge clk) disable iff (reset) // R12
		(pointerReady && fetchStep && !branchTake) |=>
		(nextFetchPointer == $past(nextFetchPointer) + {13'h0000, $past(instrLength)}))
		else $error("pointer did not advance by instruction length");

	a_branch_load: assert property (@(posedge clk) disable iff (reset) // R13
		(pointerReady && branchTake) |=> (nextFetchPointer == $past(branchTarget)))
		else $error("branch target not loaded");

	a_ram_window: assert property (@(posedge clk) disable iff (reset) // R7
		(dataAccess && dataAddr[15:7] == 9'h1FD) |-> (selHighRam && selShortWindow && !selNone && !selSfr))
		else $error("RAM window not selected");

	a_nv_window: assert property (@(posedge clk) disable iff (reset) // R8
		(dataAccess && dataAddr[15:5] == 11'h7C0) |-> (selNvData && writeAllowed == dataWrite))
		else $error("nonvolatile window not selected");

	a_sfr_window: assert property (@(posedge clk) disable iff (reset) // R9
		(dataAccess && dataAddr[15:8] == 8'hFF) |-> (selSfr && !selHighRam && selShortWindow))
		else $error("register window not selected");

	a_unmapped_quiet: assert property (@(posedge clk) disable iff (reset) // R16
		(dataAccess && ((dataAddr > address_map_pkg::PROG_ROM_LAST && dataAddr < address_map_pkg::NV_DATA_BASE)
		|| (dataAddr > address_map_pkg::NV_DATA_LAST && dataAddr < address_map_pkg::HIGH_RAM_BASE)))
		|-> (selNone && !selProgRom && !writeAllowed))
		else $error("unmapped address selected a region");

	a_fetch_outside_zero: assert property (@(posedge clk) disable iff (reset) // R16
		(pointerReady && nextFetchPointer > address_map_pkg::PROG_ROM_LAST)
		|=> (fetchByte == address_map_pkg::UNMAPPED_BYTE))
		else $error("fetch beyond the program store not read as zero");

	a_vector_slot: assert property (@(posedge clk) disable iff (reset) // R4
		(vectorSource == 3'h6) |-> (vectorAddr == 16'h000C))
		else $error("nonvolatile vector slot wrong");
endmodule : cpu_address_map_reset_vector

`default_nettype wire

/* File: core_partner.sv */
`default_nettype none

// core fetch side: system reset pin plus sequential fetch requests
module core_partner (
	input  wire logic       resetPinN,
	input  wire logic       stepEnable,
	input  wire logic [2:0] stepLen,
	input  wire logic       pointerReady,
	output logic            reset,
	output logic            fetchStep,
	output logic [2:0]      instrLength
);
	timeunit 1ns;
	timeprecision 1ps;
	assign reset = ~resetPinN;
	// a real core only steps once the pointer is valid
	assign fetchStep = stepEnable & pointerReady;
	assign instrLength = stepLen;
endmodule : core_partner

`default_nettype wire

/* File: tb_top.sv */
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, resetPinN, reset, stepEnable, fetchStep, branchTake, dataRead, dataWrite, romLoadEnable;
	logic [2:0]  stepLen, instrLength, vectorSource;
	logic [4:0]  callSlot;
	logic [11:0] romLoadAddr;
	logic [7:0]  romLoadData, fetchByte, lo, hi, b;
	logic [15:0] branchTarget, dataAddr, nextFetchPointer, vectorAddr, callTableAddr, expPtr;
	logic [8:0]  sel, es;
	logic        pointerReady;
	int          err_count, samples_checked, cnt;
	logic [15:0] corners [18] = '{16'h0000, 16'h000D, 16'h000E, 16'h003F, 16'h0040, 16'h007F, 16'h0080,
		16'h0FFF, 16'h1000, 16'hF7FF, 16'hF800, 16'hF81F, 16'hF820, 16'hFE7F, 16'hFE80, 16'hFEFF,
		16'hFF00, 16'hFFFF};

	core_partner core_u (.resetPinN(resetPinN), .stepEnable(stepEnable), .stepLen(stepLen),
		.pointerReady(pointerReady), .reset(reset), .fetchStep(fetchStep), .instrLength(instrLength));
	cpu_address_map_reset_vector dut_u (.clk(clk), .reset(reset), .fetchStep(fetchStep),
		.instrLength(instrLength), .branchTake(branchTake), .branchTarget(branchTarget),
		.vectorSource(vectorSource), .callSlot(callSlot), .dataAddr(dataAddr), .dataRead(dataRead),
		.dataWrite(dataWrite), .romLoadEnable(romLoadEnable), .romLoadAddr(romLoadAddr),
		.romLoadData(romLoadData), .nextFetchPointer(nextFetchPointer), .pointerReady(pointerReady),
		.fetchByte(fetchByte), .vectorAddr(vectorAddr), .callTableAddr(callTableAddr),
		.selVectorTable(sel[0]), .selCallTable(sel[1]), .selProgRom(sel[2]), .selNvData(sel[3]),
		.selHighRam(sel[4]), .selSfr(sel[5]), .selShortWindow(sel[6]), .selNone(sel[7]),
		.writeAllowed(sel[8]));

	// regions overlap on purpose: vector and call table sit inside the program store
	function automatic logic [8:0] expSel(input logic [15:0] a);
		logic [8:0] s;
		s[0] = a <= 16'h000D;
		s[1] = a >= 16'h0040 && a <= 16'h007F;
		s[2] = a <= 16'h0FFF;
		s[3] = a >= 16'hF800 && a <= 16'hF81F;
		s[4] = a >= 16'hFE80 && a <= 16'hFEFF;
		s[5] = a >= 16'hFF00;
		s[6] = a >= 16'hFE80;
		s[7] = !(s[2] | s[3] | s[4] | s[5]);
		s[8] = s[3] | s[4] | s[5];
		return s;
	endfunction : expSel

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	// inputs only move at the falling edge
	task automatic decodeOne(input logic [15:0] a, input logic [1:0] m);
		@(negedge clk);
		dataAddr = a;
		dataRead = m[0];
		dataWrite = m[1];
		es = (m != 2'h0) ? expSel(a) : 9'h000;
		// a read alone never opens a write
		es[8] = es[8] & m[1];
		#1 check(16'(sel), 16'(es));
	endtask : decodeOne

	task automatic loadByte(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk);
		romLoadEnable = 1'b1;
		romLoadAddr = a;
		romLoadData = d;
		@(negedge clk);
		romLoadEnable = 1'b0;
	endtask : loadByte

	task automatic step(input logic br, input logic [15:0] tgt, input logic [2:0] len);
		@(negedge clk);
		branchTake = br;
		branchTarget = tgt;
		stepEnable = 1'b1;
		stepLen = len;
		expPtr = br ? tgt : expPtr + 16'(len);
		@(posedge clk);
		#1 check(nextFetchPointer, expPtr);
	endtask : step

	// free-running 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// cut a hang short well past the expected run length
	initial begin
		#100us;
		err_count++;
		report_and_stop();
	end

	initial begin
		{resetPinN, stepEnable, branchTake, dataRead, dataWrite, romLoadEnable} = 6'h00;
		{stepLen, vectorSource, callSlot, romLoadAddr, romLoadData} = '0;
		{branchTarget, dataAddr} = '0;
		err_count = 0;
		samples_checked = 0;
		void'($urandom(28));
		lo = 8'($urandom_range(255, 2));
		hi = 8'($urandom_range(15, 0));
		b = 8'($urandom);
		// program the store while reset holds, so the first vector read is defined
		loadByte(12'h000, lo);
		loadByte(12'h001, hi);
		loadByte({hi[3:0], lo}, b);
		repeat (6) @(negedge clk);
		resetPinN = 1'b1;
		for (int i = 0; i < 18; i++) decodeOne(corners[i], 2'(i % 4));
		for (int i = 0; i < 60; i++) decodeOne(16'($urandom), 2'($urandom));
		check(nextFetchPointer, {hi, lo});
		$display("test decode done");
		for (int v = 0; v < 8; v++) begin
			@(negedge clk);
			vectorSource = 3'(v);
			#1 check(vectorAddr, (v == 7) ? 16'h0000 : 16'(2 * v));
		end
		for (int c = 0; c < 32; c++) begin
			@(negedge clk);
			callSlot = 5'(c);
			#1 check(callTableAddr, 16'h0040 + 16'(2 * c));
		end
		$display("test vector and call table done");
		// second reset; a branch held meanwhile must be ignored
		@(negedge clk);
		resetPinN = 1'b0;
		branchTake = 1'b1;
		branchTarget = 16'($urandom);
		repeat (3) @(negedge clk);
		resetPinN = 1'b1;
		cnt = 0;
		while (pointerReady !== 1'b1 && cnt < 8) begin
			@(negedge clk);
			cnt++;
		end
		branchTake = 1'b0;
		check(16'(cnt), 16'h0003);
		check(nextFetchPointer, {hi, lo});
		@(posedge clk);
		#1 check(16'(fetchByte), 16'(b));
		$display("test reset vector done");
		expPtr = {hi, lo};
		for (int i = 0; i < 40; i++) step(1'b0, 16'h0000, 3'($urandom));
		step(1'b1, 16'($urandom), 3'h5);
		step(1'b1, 16'hFFFE, 3'h0);
		step(1'b0, 16'h0000, 3'h3);
		check(16'(fetchByte), 16'h0000);
		@(negedge clk);
		stepEnable = 1'b0;
		$display("test stepping and branching done");
		report_and_stop();
	end
endmodule : tb_top

`default_nettype wire
